// *** src/php_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Select captured on falling edge of strobe
// - Write data latched on write strobe rise
// - Read drives bus, released on rise
// - Eight-bit two-way program bus, strobe sets direction
// - Mode pin high eight-bit, low six-bit
// - Asynchronous host access, spacing in pixel clocks
// - Table value per channel drives DAC code
// - Select 0 loads address, restarts byte sequence
// - Select 3 loads address, prefetches, increments
// - Select 1 three bytes RGB, then store
// - Select 2 pixel mask ANDs pixel address
module php_host_port #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 256
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // Host pins, asynchronous
   input  wire logic              wr_n,
   input  wire logic              rd_n,
   input  wire logic [1:0]        register_select,
   input  wire logic [DATA_W-1:0] program_bus_in,
   output logic      [DATA_W-1:0] program_bus_out,
   output logic                   program_bus_oe,
   input  wire logic              mode_8bit,
   // Pixel side, same clock
   input  wire logic [7:0]        pixel_address,
   output var php_pkg::php_rgb_t  dac_code
);

   // Synchronisers; stage 1 is read only by stage 2
   logic [2:0]        wr_sync_reg;
   logic [2:0]        rd_sync_reg;
   logic [1:0]        mode_sync_reg;
   logic [1:0]        sel_sync1_reg;
   logic [1:0]        sel_sync2_reg;
   logic [DATA_W-1:0] data_sync1_reg;
   logic [DATA_W-1:0] data_sync2_reg;

   logic [1:0]          sel_reg;
   logic [1:0]          sel_next;
   logic [7:0]          addr_reg;
   logic [7:0]          mask_reg;
   logic [23:0]         buf_reg;
   php_pkg::php_phase_t phase_reg;
   logic                rd_act_reg;
   logic [DATA_W-1:0]   out_reg;
   logic [DATA_W-1:0]   out_next;
   logic [23:0]         lut_mem [DEPTH];
   php_pkg::php_rgb_t   dac_reg;

   // Two stages of latency each way: strobes must stay apart a few clocks
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_sync_reg    <= 3'h7;
         rd_sync_reg    <= 3'h7;
         mode_sync_reg  <= 2'h0;
         sel_sync1_reg  <= 2'h0;
         sel_sync2_reg  <= 2'h0;
         data_sync1_reg <= '0;
         data_sync2_reg <= '0;
      end else begin
         wr_sync_reg    <= {wr_sync_reg[1:0], wr_n};
         rd_sync_reg    <= {rd_sync_reg[1:0], rd_n};
         mode_sync_reg  <= {mode_sync_reg[0], mode_8bit};
         sel_sync1_reg  <= register_select;
         sel_sync2_reg  <= sel_sync1_reg;
         data_sync1_reg <= program_bus_in;
         data_sync2_reg <= data_sync1_reg;
      end
   end

   wire logic wr_fall = !wr_sync_reg[1] && wr_sync_reg[2];
   wire logic wr_rise = wr_sync_reg[1] && !wr_sync_reg[2];
   wire logic rd_fall = !rd_sync_reg[1] && rd_sync_reg[2];
   wire logic rd_rise = rd_sync_reg[1] && !rd_sync_reg[2];
   wire logic mode8   = mode_sync_reg[1];

   // Six-bit mode keeps only the low six bits of each colour byte
   wire logic [7:0] byte_mask = mode8 ? 8'hFF : php_pkg::SIX_BIT_MASK;
   wire logic [7:0] wr_byte   = data_sync2_reg[7:0] & byte_mask;

   wire logic is_addr   = (sel_reg == php_pkg::SEL_ADDR_WR) || (sel_reg == php_pkg::SEL_ADDR_RD);
   wire logic is_colour = (sel_reg == php_pkg::SEL_COLOUR);
   wire logic last_byte = (phase_reg == php_pkg::PH_BLUE);
   wire logic [23:0] lut_at_addr = lut_mem[addr_reg];
   wire logic [23:0] lut_at_data = lut_mem[data_sync2_reg[7:0]];
   wire logic [23:0] buf_filled  = {buf_reg[23:8], wr_byte};

   wire logic [7:0] buf_byte =
      (phase_reg == php_pkg::PH_RED)   ? buf_reg[php_pkg::RED_POS +: 8] :
      (phase_reg == php_pkg::PH_GREEN) ? buf_reg[php_pkg::GREEN_POS +: 8] :
                                         buf_reg[php_pkg::BLUE_POS +: 8];

   assign sel_next = (wr_fall || rd_fall) ? sel_sync2_reg : sel_reg;
   assign out_next = (sel_next == php_pkg::SEL_MASK)   ? mask_reg :
                     (sel_next == php_pkg::SEL_COLOUR) ? (buf_byte & byte_mask) :
                                                         addr_reg;

   // Host register file
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sel_reg    <= php_pkg::SEL_ADDR_WR;
         addr_reg   <= php_pkg::ADDR_RESET;
         mask_reg   <= php_pkg::MASK_RESET;
         buf_reg    <= php_pkg::LUT_RESET;
         phase_reg  <= php_pkg::PH_RED;
         rd_act_reg <= 1'b0;
         out_reg    <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            lut_mem[i] <= php_pkg::LUT_RESET;
         end
      end else begin
         sel_reg <= sel_next;
         out_reg <= out_next;
         if (rd_fall) begin
            rd_act_reg <= 1'b1;
         end else if (rd_rise) begin
            rd_act_reg <= 1'b0;
         end
         if (wr_rise) begin
            case (sel_reg)
               php_pkg::SEL_ADDR_WR: begin
                  addr_reg  <= data_sync2_reg[7:0];
                  phase_reg <= php_pkg::PH_RED;
               end
               php_pkg::SEL_ADDR_RD: begin
                  buf_reg   <= lut_at_data;
                  addr_reg  <= data_sync2_reg[7:0] + 8'h01;
                  phase_reg <= php_pkg::PH_RED;
               end
               php_pkg::SEL_COLOUR: begin
                  case (phase_reg)
                     php_pkg::PH_RED: begin
                        buf_reg[php_pkg::RED_POS +: 8] <= wr_byte;
                        phase_reg <= php_pkg::PH_GREEN;
                     end
                     php_pkg::PH_GREEN: begin
                        buf_reg[php_pkg::GREEN_POS +: 8] <= wr_byte;
                        phase_reg <= php_pkg::PH_BLUE;
                     end
                     default: begin
                        buf_reg             <= buf_filled;
                        lut_mem[addr_reg]   <= buf_filled;
                        addr_reg            <= addr_reg + 8'h01;
                        phase_reg           <= php_pkg::PH_RED;
                     end
                  endcase
               end
               default: begin
                  mask_reg <= data_sync2_reg[7:0];
               end
            endcase
         end else if (rd_rise && is_colour) begin
            if (last_byte) begin
               buf_reg   <= lut_at_addr;
               addr_reg  <= addr_reg + 8'h01;
               phase_reg <= php_pkg::PH_RED;
            end else if (phase_reg == php_pkg::PH_RED) begin
               phase_reg <= php_pkg::PH_GREEN;
            end else begin
               phase_reg <= php_pkg::PH_BLUE;
            end
         end
      end
   end

   assign program_bus_out = out_reg;
   assign program_bus_oe  = rd_act_reg;

   // Pixel path: masked address into the table, one clock to the DAC codes
   wire logic [7:0]  pix_masked = pixel_address & mask_reg;
   wire logic [23:0] lut_pix    = lut_mem[pix_masked];
   wire logic [7:0]  red_code   = lut_pix[php_pkg::RED_POS +: 8] & byte_mask;
   wire logic [7:0]  green_code = lut_pix[php_pkg::GREEN_POS +: 8] & byte_mask;
   wire logic [7:0]  blue_code  = lut_pix[php_pkg::BLUE_POS +: 8] & byte_mask;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dac_reg <= '0;
      end else begin
         dac_reg <= '{red: red_code, green: green_code, blue: blue_code};
      end
   end

   assign dac_code = dac_reg;

   // Checks
   sequence colour_last_s;
      wr_rise && is_colour && last_byte;
   endsequence

   sequence addr_bumped_s;
      addr_reg == $past(addr_reg) + 8'h01;
   endsequence

   sel_capture_a: assert property (@(posedge core_clk) disable iff (srst)
      (wr_fall || rd_fall) |=> sel_reg == $past(sel_sync2_reg))
      else $error("select not captured on strobe fall");

   mask_latch_a: assert property (@(posedge core_clk) disable iff (srst)
      (wr_rise && sel_reg == php_pkg::SEL_MASK) |=> mask_reg == $past(data_sync2_reg))
      else $error("mask not latched on write rise");

   bus_release_a: assert property (@(posedge core_clk) disable iff (srst)
      rd_rise |=> !program_bus_oe)
      else $error("bus not released after read");

   // Address stays put for the whole read, so the registered copy must match it
   addr_read_a: assert property (@(posedge core_clk) disable iff (srst)
      (program_bus_oe && is_addr) |-> program_bus_out == addr_reg)
      else $error("address read returns wrong value");

   bus_drive_a: assert property (@(posedge core_clk) disable iff (srst)
      rd_fall |=> program_bus_oe && program_bus_out == $past(out_next))
      else $error("bus not driven during read");

   six_bit_a: assert property (@(posedge core_clk) disable iff (srst)
      !mode8 |=> dac_code.red[7:6] == 2'h0 && dac_code.blue[7:6] == 2'h0)
      else $error("six-bit mode code too wide");

   dac_code_a: assert property (@(posedge core_clk) disable iff (srst)
      mode8 |=> dac_code == $past(lut_pix))
      else $error("DAC code differs from table entry");

   addr_load_a: assert property (@(posedge core_clk) disable iff (srst)
      (wr_rise && sel_reg == php_pkg::SEL_ADDR_WR)
      |=> addr_reg == $past(data_sync2_reg) && phase_reg == php_pkg::PH_RED)
      else $error("address write did not load or restart");

   addr_prefetch_a: assert property (@(posedge core_clk) disable iff (srst)
      (wr_rise && sel_reg == php_pkg::SEL_ADDR_RD)
      |=> addr_reg == $past(data_sync2_reg) + 8'h01 && buf_reg == $past(lut_at_data))
      else $error("read address setup wrong");

   colour_store_a: assert property (@(posedge core_clk) disable iff (srst)
      colour_last_s |=> addr_bumped_s ##0 lut_mem[$past(addr_reg)] == $past(buf_filled))
      else $error("colour entry not stored");

endmodule : php_host_port

`default_nettype wire

// *** src/php_pkg.sv ***
package php_pkg;

   // Register select codes
   localparam logic [1:0] SEL_ADDR_WR = 2'h0;
   localparam logic [1:0] SEL_COLOUR  = 2'h1;
   localparam logic [1:0] SEL_MASK    = 2'h2;
   localparam logic [1:0] SEL_ADDR_RD = 2'h3;

   // Reset values
   localparam logic [7:0]  ADDR_RESET = 8'h00;
   localparam logic [7:0]  MASK_RESET = 8'hFF;
   localparam logic [23:0] LUT_RESET  = 24'h000000;

   // Field layout of one colour entry
   localparam int RED_POS   = 16;
   localparam int GREEN_POS = 8;
   localparam int BLUE_POS  = 0;
   localparam logic [7:0] SIX_BIT_MASK = 8'h3F;

   typedef enum logic [1:0] {
      PH_RED,
      PH_GREEN,
      PH_BLUE
   } php_phase_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } php_rgb_t;

endpackage : php_pkg

// *** testbench/php_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module php_host_model (
   // Clock and bus level
   input  wire logic       core_clk,
   input  wire logic [7:0] bus,
   // Host pins
   output logic            wr_n,
   output logic            rd_n,
   output logic [1:0]      sel,
   output logic [7:0]      dout
);
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      sel  = 2'h0;
      dout = 8'h00;
   end
   // One strobe at a time, levels held past the sync delay
   task automatic strobe(input logic w, input logic [1:0] s,
                         input logic [7:0] d, output logic [7:0] q);
      sel  <= s;
      dout <= d;
      repeat (4) @(posedge core_clk);
      if (w) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      // Select only held past the fall; the device must keep its copy
      sel <= ~s;
      @(posedge core_clk);
      q = bus;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      // Stale data never looks valid after the hold time
      dout <= ~d;
      repeat (2) @(posedge core_clk);
   endtask : strobe
endmodule : php_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic w; logic [1:0] s; logic [7:0] d;} php_row_t;
   logic              core_clk = 1'b0;
   logic              srst = 1'b1;
   logic              mode_8bit = 1'b1;
   logic [7:0]        pixel_address = 8'h00;
   logic              wr_n, rd_n, oe;
   logic [1:0]        sel;
   logic [7:0]        dout, bus_out, q;
   wire logic [7:0]   bus = oe ? bus_out : dout;
   php_pkg::php_rgb_t dac_code;
   int                failures = 0;
   int                comparisons = 0;
   // Writes carry data, reads carry the expected byte
   php_row_t rows [12] = '{'{1'b1, 2'h0, 8'h10}, '{1'b1, 2'h1, 8'hAA},
      '{1'b1, 2'h1, 8'h55}, '{1'b1, 2'h1, 8'hC3}, '{1'b0, 2'h0, 8'h11},
      '{1'b1, 2'h3, 8'h10}, '{1'b0, 2'h1, 8'hAA}, '{1'b0, 2'h1, 8'h55},
      '{1'b0, 2'h1, 8'hC3}, '{1'b0, 2'h3, 8'h12}, '{1'b1, 2'h2, 8'hF0},
      '{1'b0, 2'h2, 8'hF0}};

   always #5 core_clk = ~core_clk;

   php_host_model u_host (.core_clk(core_clk), .bus(bus), .wr_n(wr_n),
      .rd_n(rd_n), .sel(sel), .dout(dout));
   php_host_port u_dut (.core_clk(core_clk), .srst(srst), .wr_n(wr_n),
      .rd_n(rd_n), .register_select(sel), .program_bus_in(bus),
      .program_bus_out(bus_out), .program_bus_oe(oe), .mode_8bit(mode_8bit),
      .pixel_address(pixel_address), .dac_code(dac_code));

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_rgb(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: dac %h expected %h", $time, got, exp);
      end
   endtask : check_rgb

   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      u_host.strobe(1'b1, s, d, q);
      check_byte({7'h00, oe}, 8'h00);
   endtask : wr

   task automatic rd(input logic [1:0] s, input logic [7:0] e);
      u_host.strobe(1'b0, s, 8'h00, q);
      check_byte(q, e);
      check_byte({7'h00, oe}, 8'h00);
   endtask : rd

   task automatic pixel(input logic [7:0] a, input logic [23:0] e);
      pixel_address <= a;
      repeat (3) @(posedge core_clk);
      check_rgb(dac_code, e);
   endtask : pixel

   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      check_byte({7'h00, oe}, 8'h00);
      check_rgb(dac_code, 24'h000000);
      rd(2'h2, 8'hFF);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].s, rows[i].d);
         else rd(rows[i].s, rows[i].d);
      end
      pixel(8'h1F, 24'hAA55C3);
      $display("row test done");
      // Address write in mid-triplet must restart at red
      wr(2'h0, 8'h30);
      wr(2'h1, 8'h11);
      wr(2'h0, 8'h30);
      wr(2'h1, 8'h22);
      wr(2'h1, 8'h33);
      wr(2'h1, 8'h44);
      pixel(8'h3F, 24'h223344);
      $display("restart test done");
      mode_8bit <= 1'b0;
      wr(2'h0, 8'h50);
      repeat (3) wr(2'h1, 8'hFF);
      wr(2'h3, 8'h50);
      repeat (3) rd(2'h1, 8'h3F);
      pixel(8'h5A, 24'h3F3F3F);
      $display("six-bit test done");
      // Second reset in mid-run must clear address and mask; the pixel read hits entry 5A, which was never written
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      check_byte({7'h00, oe}, 8'h00);
      check_rgb(dac_code, 24'h000000);
      rd(2'h2, 8'hFF);
      rd(2'h0, 8'h00);
      pixel(8'h5A, 24'h000000);
      $display("mid-run reset test done");
      stop_test();
   end

   // Run needs well under 20 us
   initial begin
      #50us;
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
